// File: hdl/mcuie_params.svh
// Offsets, field positions, page limits, wake vector and instruction count of the execute unit
`ifndef MCUIE_PARAMS_SVH
`define MCUIE_PARAMS_SVH
`define MCUIE_STATUS_C 0
`define MCUIE_STATUS_DC 1
`define MCUIE_STATUS_Z 2
`define MCUIE_STATUS_PD 3
`define MCUIE_STATUS_TO 4
`define MCUIE_RPAGE_MAX 8'h3f
`define MCUIE_TPAGE_MAX 8'h7f
`define MCUIE_FPAGE_MIN 8'h05
`define MCUIE_FPAGE_MAX 8'h0f
`define MCUIE_SPAGE_MAX 8'h13
`define MCUIE_WAKE_VECTOR 11'h008
`define MCUIE_INSTR_COUNT 55
`endif

// File: hdl/mcuie_pkg.sv
// Types shared by the execute unit and its arithmetic core
package mcuie_pkg;
  // Operation classes, one per decoded instruction
  typedef enum logic [5:0] {
    OP_NOP, OP_AND_R, OP_IOR_R, OP_XOR_R, OP_AND_I, OP_IOR_I, OP_XOR_I,
    OP_RRR, OP_RLR, OP_BSR, OP_BCR, OP_INCR, OP_DECR, OP_COMR,
    OP_TEST_BIT_SKIP_CLEAR, OP_TEST_BIT_SKIP_SET, OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO,
    OP_MOVAR, OP_MOVR, OP_MOVIA, OP_SWAPR, OP_PORT_PAGE_WRITE, OP_PORT_PAGE_READ,
    OP_SECOND_PAGE_WRITE, OP_SECOND_PAGE_READ, OP_TIMER_MODE_WRITE, OP_TIMER_MODE_READ, OP_TABLE_READ,
    OP_ADD_REG_ACC, OP_SUB_REG_ACC, OP_ADD_REG_ACC_CARRY, OP_SUB_REG_ACC_BORROW,
    OP_ADD_I, OP_SUB_I, OP_ADC_I, OP_SBC_I, OP_DECIMAL_ADJUST, OP_CMPAR, OP_CLRA, OP_CLRR,
    OP_THIRD_PAGE_WRITE, OP_THIRD_PAGE_READ, OP_SLEEP, OP_WATCHDOG_CLEAR_INSTR,
    OP_INTERRUPT_ENABLE_INSTR, OP_DISI, OP_SOFT_INT, OP_RET, OP_RETIE, OP_RETIA,
    OP_INDEXED_CALL, OP_INDEXED_JUMP, OP_LCALL, OP_LGOTO
  } mcuie_op_t;

  // One pre-decoded instruction word
  typedef struct packed {
    mcuie_op_t op;
    logic dest;
    logic [7:0] operand;
    logic [2:0] bit_idx;
    logic [10:0] target;
  } mcuie_instr_t;

  // Flag set returned by the arithmetic core
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mcuie_flags_t;

  // Special register transfer request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } mcuie_sfr_t;
endpackage

// File: hdl/mcuie_alu.sv
// Combinational arithmetic and logic core of the execute unit
`timescale 1ns/1ns
`include "mcuie_params.svh"
module mcuie_alu
  import mcuie_pkg::*;
(
  input wire mcuie_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] reg_val,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_idx,
  input wire mcuie_flags_t flags_in,
  output logic [7:0] result,
  output mcuie_flags_t flags_out
);
  // Nine-bit add that also reports the nibble carry
  function automatic logic [9:0] add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    add9 = {lo[4], full};
  endfunction

  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire [7:0] inv_acc = ~acc;
  wire z_logic = op inside {OP_AND_R, OP_IOR_R, OP_XOR_R, OP_AND_I, OP_IOR_I, OP_XOR_I, OP_COMR, OP_MOVR, OP_INCR, OP_DECR};
  wire [9:0] s_add_r = add9(reg_val, acc, 1'b0);
  wire [9:0] s_adc_r = add9(reg_val, acc, flags_in.c);
  wire [9:0] s_sub_r = add9(reg_val, inv_acc, 1'b1);
  wire [9:0] s_sbc_r = add9(reg_val, inv_acc, flags_in.c);
  wire [9:0] s_add_i = add9(imm, acc, 1'b0);
  wire [9:0] s_adc_i = add9(imm, acc, flags_in.c);
  wire [9:0] s_sub_i = add9(imm, inv_acc, 1'b1);
  wire [9:0] s_sbc_i = add9(imm, inv_acc, flags_in.c);
  // Decimal adjust after a packed BCD addition
  wire lo_fix = flags_in.dc || (acc[3:0] > 4'h9);
  wire [8:0] da_lo = {1'b0, acc} + (lo_fix ? 9'h006 : 9'h000);
  wire hi_fix = flags_in.c || da_lo[8] || (da_lo[7:4] > 4'h9);
  wire [8:0] da_all = {1'b0, da_lo[7:0]} + (hi_fix ? 9'h060 : 9'h000);

  // Result and flag selection; unlisted flags pass through
  always_comb begin
    logic [9:0] sum;
    sum = 10'h000;
    result = 8'h00;
    flags_out = flags_in;
    case (op)
      OP_ADD_REG_ACC: sum = s_add_r;
      OP_ADD_REG_ACC_CARRY: sum = s_adc_r;
      OP_SUB_REG_ACC, OP_CMPAR: sum = s_sub_r;
      OP_SUB_REG_ACC_BORROW: sum = s_sbc_r;
      OP_ADD_I: sum = s_add_i;
      OP_ADC_I: sum = s_adc_i;
      OP_SUB_I: sum = s_sub_i;
      OP_SBC_I: sum = s_sbc_i;
      default: sum = 10'h000;
    endcase
    case (op)
      OP_ADD_REG_ACC, OP_ADD_REG_ACC_CARRY, OP_SUB_REG_ACC, OP_SUB_REG_ACC_BORROW,
      OP_ADD_I, OP_ADC_I, OP_SUB_I, OP_SBC_I: begin
        result = sum[7:0];
        flags_out.c = sum[8];
        flags_out.dc = sum[9];
        flags_out.z = (sum[7:0] == 8'h00);
      end
      OP_CMPAR: begin
        result = reg_val;
        flags_out.c = sum[8];
        flags_out.z = (sum[7:0] == 8'h00);
      end
      OP_AND_R: result = acc & reg_val;
      OP_IOR_R: result = acc | reg_val;
      OP_XOR_R: result = acc ^ reg_val;
      OP_AND_I: result = acc & imm;
      OP_IOR_I: result = acc | imm;
      OP_XOR_I: result = acc ^ imm;
      OP_COMR: result = ~reg_val;
      OP_MOVR: result = reg_val;
      OP_INCR: result = reg_val + 8'h01;
      OP_DECR: result = reg_val - 8'h01;
      OP_INCREMENT_SKIP_ZERO: result = reg_val + 8'h01;
      OP_DECREMENT_SKIP_ZERO: result = reg_val - 8'h01;
      OP_RRR: begin result = {flags_in.c, reg_val[7:1]}; flags_out.c = reg_val[0]; end
      OP_RLR: begin result = {reg_val[6:0], flags_in.c}; flags_out.c = reg_val[7]; end
      OP_BSR: result = reg_val | bit_mask;
      OP_BCR: result = reg_val & ~bit_mask;
      OP_SWAPR: result = {reg_val[3:0], reg_val[7:4]};
      OP_MOVAR: result = acc;
      OP_MOVIA, OP_RETIA: result = imm;
      OP_CLRA, OP_CLRR: begin result = 8'h00; flags_out.z = 1'b1; end
      OP_DECIMAL_ADJUST: begin
        result = da_all[7:0];
        flags_out.c = hi_fix;
      end
      default: result = acc;
    endcase
    if (z_logic) flags_out.z = (result == 8'h00);
  end
endmodule // mcuie_alu

// File: hdl/mcuie_core.sv
// Decode and execute stage of the 8-bit controller core
`timescale 1ns/1ns
`include "mcuie_params.svh"
module mcuie_core
  import mcuie_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire mcuie_instr_t instr,
  input wire logic instr_valid,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] table_rdata,
  input wire logic wdt_timeout,
  input wire logic wake_event,
  input wire logic [PC_W-1:0] pc_cur,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output mcuie_sfr_t sfr_req,
  output logic [PC_W-1:0] pc_target,
  output logic pc_load,
  output logic flush,
  output logic halted,
  output logic wdt_clear,
  output logic int_enable,
  output logic table_req,
  output logic [7:0] accumulator,
  output logic [7:0] status
);
  // ------------------------------------------------------------
  // Execute sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_HALT} mcuie_state_t;

  mcuie_state_t state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt;
  mcuie_flags_t flags_r;
  logic pd_r, to_r, gie_r;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp_r;
  logic [7:0] result;
  mcuie_flags_t alu_flags;

  // Flush the slot after a skip, a taken branch or a table read
  function automatic logic is_two_cycle(input mcuie_op_t op);
    is_two_cycle = (op == OP_SOFT_INT) || (op == OP_RET) || (op == OP_RETIE) || (op == OP_RETIA) ||
                   (op == OP_INDEXED_CALL) || (op == OP_INDEXED_JUMP) || (op == OP_LCALL) ||
                   (op == OP_LGOTO) || (op == OP_TABLE_READ);
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire exec = instr_valid && (state_r == ST_RUN);
  wire mcuie_op_t op = instr.op;
  wire [5:0] raddr = instr.operand[5:0];
  wire rd_bit = reg_rdata[instr.bit_idx];
  wire skip_op = (op == OP_TEST_BIT_SKIP_CLEAR && !rd_bit) ||
                 (op == OP_TEST_BIT_SKIP_SET && rd_bit) ||
                 ((op == OP_INCREMENT_SKIP_ZERO || op == OP_DECREMENT_SKIP_ZERO) && result == 8'h00);
  wire two_cyc = exec && (skip_op || is_two_cycle(op));
  wire dest_ops = (op == OP_AND_R) || (op == OP_IOR_R) || (op == OP_XOR_R) || (op == OP_RRR) ||
                  (op == OP_RLR) || (op == OP_INCR) || (op == OP_DECR) || (op == OP_COMR) ||
                  (op == OP_MOVR) || (op == OP_SWAPR) || (op == OP_ADD_REG_ACC) ||
                  (op == OP_SUB_REG_ACC) || (op == OP_ADD_REG_ACC_CARRY) ||
                  (op == OP_SUB_REG_ACC_BORROW) || (op == OP_INCREMENT_SKIP_ZERO) ||
                  (op == OP_DECREMENT_SKIP_ZERO);
  wire reg_only = (op == OP_BSR) || (op == OP_BCR) || (op == OP_MOVAR) || (op == OP_CLRR);
  wire acc_only = (op == OP_AND_I) || (op == OP_IOR_I) || (op == OP_XOR_I) || (op == OP_ADD_I) ||
                  (op == OP_SUB_I) || (op == OP_ADC_I) || (op == OP_SBC_I) || (op == OP_MOVIA) ||
                  (op == OP_DECIMAL_ADJUST) || (op == OP_CLRA) || (op == OP_RETIA);
  wire to_reg = dest_ops && instr.dest;
  wire to_acc = (dest_ops && !instr.dest) || acc_only;
  wire flags_upd = exec && !(op == OP_INCREMENT_SKIP_ZERO || op == OP_DECREMENT_SKIP_ZERO);

  // Page range checks for special register transfers
  wire t_ok = instr.operand <= `MCUIE_TPAGE_MAX;
  wire f_ok = instr.operand >= `MCUIE_FPAGE_MIN && instr.operand <= `MCUIE_FPAGE_MAX;
  wire s_ok = instr.operand <= `MCUIE_SPAGE_MAX;
  wire sfr_wr = exec && ((op == OP_THIRD_PAGE_WRITE && t_ok) || (op == OP_PORT_PAGE_WRITE && f_ok) ||
                         (op == OP_SECOND_PAGE_WRITE && s_ok) || op == OP_TIMER_MODE_WRITE);
  wire sfr_rd_op = (op == OP_THIRD_PAGE_READ && t_ok) || (op == OP_PORT_PAGE_READ && f_ok) ||
                   (op == OP_SECOND_PAGE_READ && s_ok) || op == OP_TIMER_MODE_READ;
  wire [1:0] sfr_page = (op == OP_THIRD_PAGE_WRITE || op == OP_THIRD_PAGE_READ) ? 2'h3 :
                        (op == OP_PORT_PAGE_WRITE || op == OP_PORT_PAGE_READ) ? 2'h1 :
                        (op == OP_SECOND_PAGE_WRITE || op == OP_SECOND_PAGE_READ) ? 2'h2 : 2'h0;

  // Branch targets; indexed forms splice the accumulator into the low byte
  wire [PC_W-1:0] acc_target = {pc_cur[PC_W-1:8], acc_r};
  wire is_call = (op == OP_INDEXED_CALL) || (op == OP_LCALL) || (op == OP_SOFT_INT);
  wire is_ret = (op == OP_RET) || (op == OP_RETIE) || (op == OP_RETIA);
  wire [PC_W-1:0] ret_addr = stack_r[sp_r - 1'b1];
  wire [PC_W-1:0] wake_vec = PC_W'(`MCUIE_WAKE_VECTOR);

  mcuie_alu u_alu (
    .op(op),
    .acc(acc_r),
    .reg_val(reg_rdata),
    .imm(instr.operand),
    .bit_idx(instr.bit_idx),
    .flags_in(flags_r),
    .result(result),
    .flags_out(alu_flags)
  );

  // ------------------------------------------------------------
  // Next state and accumulator
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (state_r == ST_HALT) begin
      if (wake_event) state_nxt = ST_RUN;
    end else if (state_r == ST_IDLE) begin
      state_nxt = ST_RUN;
    end else if (exec && op == OP_SLEEP) begin
      state_nxt = ST_HALT;
    end else if (two_cyc) begin
      state_nxt = ST_IDLE;
    end
  end

  // Accumulator takes ALU result, special register data or table byte
  always_comb begin
    acc_nxt = acc_r;
    if (exec && to_acc) acc_nxt = result;
    else if (exec && sfr_rd_op) acc_nxt = sfr_rdata;
    else if (state_r == ST_IDLE && table_req) acc_nxt = table_rdata;
  end

  // Register file and control outputs
  assign reg_addr = raddr;
  assign reg_wdata = result;
  assign reg_we = exec && (to_reg || reg_only);
  assign sfr_req = '{wr: sfr_wr, rd: exec && sfr_rd_op, page: sfr_page, addr: instr.operand, data: acc_r};
  assign pc_load = (exec && (op == OP_INDEXED_CALL || op == OP_INDEXED_JUMP || op == OP_LCALL ||
                   op == OP_LGOTO || op == OP_SOFT_INT || is_ret)) ||
                   (state_r == ST_HALT && wake_event && gie_r);
  assign pc_target = (state_r == ST_HALT || op == OP_SOFT_INT) ? wake_vec :
                     (op == OP_INDEXED_CALL || op == OP_INDEXED_JUMP) ? acc_target :
                     is_ret ? ret_addr : instr.target;
  assign flush = two_cyc;
  assign halted = (state_r == ST_HALT);
  assign wdt_clear = exec && (op == OP_SLEEP || op == OP_WATCHDOG_CLEAR_INSTR);
  assign int_enable = gie_r;
  assign accumulator = acc_r;
  assign status = {3'h0, to_r, pd_r, flags_r.z, flags_r.dc, flags_r.c};

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_RUN;
      acc_r <= 8'h00;
      flags_r <= '0;
      table_req <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      table_req <= exec && op == OP_TABLE_READ;
      if (flags_upd) flags_r <= alu_flags;
    end
  end

  // Power-down and timeout flags; a timeout in the same cycle wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pd_r <= 1'b1;
      to_r <= 1'b1;
    end else begin
      if (exec && op == OP_WATCHDOG_CLEAR_INSTR) pd_r <= 1'b1;
      else if (exec && op == OP_SLEEP) pd_r <= 1'b0;
      if (wdt_timeout) to_r <= 1'b0;
      else if (exec && (op == OP_SLEEP || op == OP_WATCHDOG_CLEAR_INSTR)) to_r <= 1'b1;
    end
  end

  // Interrupt enable; interrupt entry and return touch it too
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) gie_r <= 1'b0;
    else if (exec && (op == OP_INTERRUPT_ENABLE_INSTR || op == OP_RETIE)) gie_r <= 1'b1;
    else if (exec && (op == OP_DISI || op == OP_SOFT_INT)) gie_r <= 1'b0;
    else if (state_r == ST_HALT && wake_event && gie_r) gie_r <= 1'b0;
  end

  // Return stack; wraps silently on overflow
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sp_r <= '0;
    else if (exec && is_call) sp_r <= sp_r + 1'b1;
    else if (exec && is_ret) sp_r <= sp_r - 1'b1;
    else if (state_r == ST_HALT && wake_event && gie_r) sp_r <= sp_r + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (exec && is_call) stack_r[sp_r] <= pc_cur + 1'b1;
    else if (state_r == ST_HALT && wake_event && gie_r) stack_r[sp_r] <= pc_cur;
  end
endmodule // mcuie_core

// File: verification/mcuie_core_monitor.sv
// Port-level property checker for the execute unit
`timescale 1ns/1ns
module mcuie_core_monitor
  import mcuie_pkg::*;
#(
  parameter int PC_W = 11
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire mcuie_instr_t instr,
  input wire logic instr_valid,
  input wire logic [7:0] reg_rdata,
  input wire logic wdt_timeout,
  input wire logic [PC_W-1:0] pc_cur,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire mcuie_sfr_t sfr_req,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic pc_load,
  input wire logic flush,
  input wire logic halted,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] status
);
  logic idle_r;
  // Cycle after a flush refuses input
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) idle_r <= 1'b0;
    else idle_r <= flush;
  end
  // Accepted instruction and reference sums
  wire take = instr_valid && !halted && !idle_r;
  wire [8:0] sum_add = {1'b0, accumulator} + {1'b0, reg_rdata};
  wire [8:0] sum_adc = sum_add + {8'h00, status[0]};
  wire bit_val = reg_rdata[instr.bit_idx];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_jump_req;
    pc_load && flush && pc_target == {pc_cur[PC_W-1:8], accumulator};
  endsequence
  sequence s_idle;
    !pc_load && !reg_we && !sfr_req.wr && $stable(accumulator);
  endsequence
  property p_jump;
    take && instr.op == OP_INDEXED_JUMP |-> s_jump_req ##1 s_idle;
  endproperty
  a_jump: assert property (p_jump) else $error("jump");
  property p_call;
    take && instr.op == OP_INDEXED_CALL |-> s_jump_req ##1 s_idle;
  endproperty
  a_call: assert property (p_call) else $error("call");
  property p_add_acc;
    take && instr.op == OP_ADD_REG_ACC && !instr.dest |-> !reg_we ##1 {status[0], accumulator} == $past(sum_add);
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add");
  property p_adc_reg;
    take && instr.op == OP_ADD_REG_ACC_CARRY && instr.dest
      |-> reg_we && reg_addr == instr.operand[5:0] && reg_wdata == sum_adc[7:0] ##1 status[0] == $past(sum_adc[8]);
  endproperty
  a_adc_reg: assert property (p_adc_reg) else $error("adc");
  property p_skip_clr;
    take && instr.op == OP_TEST_BIT_SKIP_CLEAR |-> flush == !bit_val ##1 status[2:0] == $past(status[2:0]);
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip clr");
  property p_skip_set;
    take && instr.op == OP_TEST_BIT_SKIP_SET |-> flush == bit_val ##1 status[2:0] == $past(status[2:0]);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip set");
  property p_inc_skip;
    take && instr.op == OP_INCREMENT_SKIP_ZERO |-> flush == (reg_rdata == 8'hff) ##1 $stable(status[2:0]);
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("inc skip");
  property p_sleep;
    take && instr.op == OP_SLEEP && !wdt_timeout |=> halted && status[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("halt");
  property p_wdclr;
    take && instr.op == OP_WATCHDOG_CLEAR_INSTR && !wdt_timeout |=> status[4:3] == 2'b11;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("wdt clear");
  property p_timeout;
    wdt_timeout |=> !status[4];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout");
  property p_port;
    take && instr.op == OP_PORT_PAGE_WRITE |-> sfr_req.wr == (instr.operand inside {[8'h05:8'h0f]});
  endproperty
  a_port: assert property (p_port) else $error("port page");
  property p_reset;
    $rose(resetn) |-> status == 8'h18 && accumulator == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset");
endmodule // mcuie_core_monitor

bind mcuie_core mcuie_core_monitor #(.PC_W(PC_W)) u_mon (
  .ref_clk(ref_clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid), .reg_rdata(reg_rdata),
  .wdt_timeout(wdt_timeout), .pc_cur(pc_cur), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .sfr_req(sfr_req), .pc_target(pc_target), .pc_load(pc_load), .flush(flush), .halted(halted),
  .accumulator(accumulator), .status(status)
);

// File: verification/mcuie_mem_model.sv
// Register file, special registers and program memory byte source
`timescale 1ns/1ns
module mcuie_mem_model
  import mcuie_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire mcuie_sfr_t sfr_req,
  output logic [7:0] reg_rdata,
  output logic [7:0] sfr_rdata,
  output logic [7:0] table_rdata
);
  logic [7:0] regs [64];
  logic [7:0] sfrs [128];
  logic [7:0] spin = 8'h5a;
  // Reads answer at once; idle bus shows a moving pattern
  assign reg_rdata = regs[reg_addr];
  assign sfr_rdata = sfr_req.rd ? sfrs[sfr_req.addr[6:0]] : spin;
  assign table_rdata = spin;
  initial begin
    foreach (regs[i]) regs[i] = 8'(i);
    foreach (sfrs[i]) sfrs[i] = 8'(i + 3);
  end
  // Writes land on the clock edge
  always @(posedge ref_clk) begin
    spin <= {spin[6:0], spin[7] ^ spin[5]};
    if (reg_we) regs[reg_addr] <= reg_wdata;
    if (sfr_req.wr) sfrs[sfr_req.addr[6:0]] <= sfr_req.data;
  end
endmodule // mcuie_mem_model

// File: verification/tb_mcu_instruction_execute_unit.sv
// Self-checking bench for the execute unit
`timescale 1ns/1ns
module tb_mcu_instruction_execute_unit
  import mcuie_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  mcuie_instr_t instr = '0;
  logic instr_valid = 1'b0, wdt_timeout = 1'b0, wake_event = 1'b0;
  logic [10:0] pc_cur = 11'h000, pc_target, s_tg, sum;
  logic [7:0] reg_rdata, sfr_rdata, table_rdata, reg_wdata, accumulator, status, st_e, a, r, v, s_wd;
  logic [5:0] reg_addr, s_ra, ad;
  logic reg_we, pc_load, flush, halted, wdt_clear, int_enable, table_req, s_we, s_fl, s_pl, s_wc;
  mcuie_sfr_t sfr_req, s_sfr;
  int failures = 0, checks_done = 0;
  logic [31:0] seed = 32'h546a;
  mcuie_op_t pg_op [12] = '{OP_THIRD_PAGE_WRITE, OP_THIRD_PAGE_WRITE, OP_THIRD_PAGE_WRITE, OP_PORT_PAGE_WRITE,
    OP_PORT_PAGE_WRITE, OP_PORT_PAGE_WRITE, OP_PORT_PAGE_WRITE, OP_SECOND_PAGE_WRITE, OP_SECOND_PAGE_WRITE,
    OP_THIRD_PAGE_READ, OP_PORT_PAGE_READ, OP_SECOND_PAGE_READ};
  logic [7:0] pg_ad [12] = '{8'h00, 8'h7f, 8'h80, 8'h04, 8'h05, 8'h0f, 8'h10, 8'h13, 8'h14, 8'h7f, 8'h05, 8'h00};
  logic [1:0] pg_pg [12] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h2};
  logic [11:0] pg_ok = 12'b1110_1011_0011;
  logic [7:0] iv [4] = '{8'hff, 8'h00, 8'h01, 8'h02};

  // Clock, design and far-side model
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  mcuie_core dut (
    .ref_clk(ref_clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid), .reg_rdata(reg_rdata),
    .sfr_rdata(sfr_rdata), .table_rdata(table_rdata), .wdt_timeout(wdt_timeout), .wake_event(wake_event),
    .pc_cur(pc_cur), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .sfr_req(sfr_req),
    .pc_target(pc_target), .pc_load(pc_load), .flush(flush), .halted(halted), .wdt_clear(wdt_clear),
    .int_enable(int_enable), .table_req(table_req), .accumulator(accumulator), .status(status)
  );
  mcuie_mem_model u_mem (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .sfr_req(sfr_req),
    .reg_rdata(reg_rdata), .sfr_rdata(sfr_rdata), .table_rdata(table_rdata)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Sum with flags packed as {z, dc, c, result}
  function automatic logic [10:0] f_add(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  // Present one instruction, capture same-cycle answers
  task automatic issue(input mcuie_op_t op, input logic d, input logic [7:0] o, input logic [2:0] b);
    @(posedge ref_clk);
    instr <= '{op: op, dest: d, operand: o, bit_idx: b, target: 11'h000};
    instr_valid <= 1'b1;
    pc_cur <= seed[26:16];
    #1;
    s_we = reg_we;
    s_wd = reg_wdata;
    s_ra = reg_addr;
    s_fl = flush;
    s_pl = pc_load;
    s_tg = pc_target;
    s_wc = wdt_clear;
    s_sfr = sfr_req;
  endtask
  // Gap cycle doubles as the post-flush idle cycle
  task automatic run(input mcuie_op_t op, input logic d, input logic [7:0] o, input logic [2:0] b);
    issue(op, d, o, b);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic set_reg(input logic [5:0] k, input logic [7:0] x);
    run(OP_MOVIA, 1'b0, x, 3'h0);
    run(OP_MOVAR, 1'b1, {2'b00, k}, 3'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the test length
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk(status, 8'h18, "reset status");
    st_e = 8'h18;
    // Random add/subtract forms, both destinations
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      a = seed[7:0];
      r = seed[15:8];
      ad = (i == 0) ? 6'h3f : seed[21:16];
      set_reg(ad, r);
      run(OP_MOVIA, 1'b0, a, 3'h0);
      sum = f_add(seed[26] ? ~a : a, r, seed[24] ? st_e[0] : seed[26]);
      run(seed[26] ? (seed[24] ? OP_SUB_REG_ACC_BORROW : OP_SUB_REG_ACC) :
          (seed[24] ? OP_ADD_REG_ACC_CARRY : OP_ADD_REG_ACC), seed[25], {2'b00, ad}, 3'h0);
      chk(s_we, seed[25], "dest select");
      chk(s_ra, ad, "reg addr");
      if (seed[25]) chk(s_wd, sum[7:0], "reg sum");
      chk(accumulator, seed[25] ? a : sum[7:0], "acc sum");
      st_e = {st_e[7:3], sum[10:8]};
      chk(status, st_e, "add flags");
    end
    $display("add test done");
    // Every bit index, both skip senses
    for (int k = 0; k < 16; k++) begin
      if (k % 8 == 0) begin
        seed = xs(seed);
        v = seed[7:0];
        set_reg(6'h3f, v);
      end
      run(k < 8 ? OP_TEST_BIT_SKIP_CLEAR : OP_TEST_BIT_SKIP_SET, 1'b0, 8'h3f, k[2:0]);
      chk(s_fl, (k < 8) ? !v[k[2:0]] : v[k[2:0]], "bit skip");
      chk(status, st_e, "bit skip flags");
    end
    // Increment and decrement around zero
    for (int k = 0; k < 4; k++) begin
      set_reg(6'h00, iv[k]);
      run(k < 2 ? OP_INCREMENT_SKIP_ZERO : OP_DECREMENT_SKIP_ZERO, 1'b1, 8'h00, 3'h0);
      r = (k < 2) ? iv[k] + 8'h01 : iv[k] - 8'h01;
      chk(s_wd, r, "count result");
      chk(s_fl, r == 8'h00, "count skip");
      chk(status, st_e, "count flags");
    end
    $display("skip test done");
    // Page transfers at and beyond each address limit
    run(OP_MOVIA, 1'b0, 8'hc3, 3'h0);
    for (int k = 0; k < 12; k++) begin
      run(pg_op[k], 1'b0, pg_ad[k], 3'h0);
      chk({s_sfr.wr, s_sfr.rd}, k < 9 ? {pg_ok[k], 1'b0} : {1'b0, pg_ok[k]}, "page strobe");
      if (pg_ok[k]) chk({s_sfr.page, s_sfr.addr}, {pg_pg[k], pg_ad[k]}, "page addr");
      if (k < 9 && pg_ok[k]) chk(s_sfr.data, 8'hc3, "page data");
    end
    $display("page test done");
    // Indexed jump and call; idle cycle offer refused
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      run(OP_MOVIA, 1'b0, seed[7:0], 3'h0);
      issue(k ? OP_INDEXED_CALL : OP_INDEXED_JUMP, 1'b0, 8'h00, 3'h0);
      chk({s_pl, s_fl}, 2'b11, "branch req");
      chk(s_tg, {pc_cur[10:8], seed[7:0]}, "branch target");
      issue(OP_MOVIA, 1'b0, ~seed[7:0], 3'h0);
      run(OP_NOP, 1'b0, 8'h00, 3'h0);
      chk(accumulator, seed[7:0], "idle refused");
      chk(status, st_e, "branch flags");
    end
    $display("branch test done");
    // Decimal adjust after two additions
    for (int k = 0; k < 2; k++) begin
      set_reg(6'h01, k ? 8'h01 : 8'h27);
      run(OP_MOVIA, 1'b0, k ? 8'h99 : 8'h15, 3'h0);
      run(OP_ADD_REG_ACC, 1'b0, 8'h01, 3'h0);
      run(OP_DECIMAL_ADJUST, 1'b0, 8'h00, 3'h0);
      chk(accumulator, k ? 8'h00 : 8'h42, "da");
      chk(status, {7'b0001100, k[0]}, "da flags");
    end
    // Halt, refusal, wake, timeout, watchdog clear
    run(OP_SLEEP, 1'b0, 8'h00, 3'h0);
    chk({s_wc, halted, status[4:3]}, 4'b1110, "halt entry");
    run(OP_MOVIA, 1'b0, 8'h66, 3'h0);
    chk(accumulator, 8'h00, "halt refuses");
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    @(posedge ref_clk);
    wdt_timeout <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
    #1;
    chk({halted, status[4]}, 2'b00, "wake timeout");
    run(OP_WATCHDOG_CLEAR_INSTR, 1'b0, 8'h00, 3'h0);
    chk({s_wc, status[4:3]}, 3'b111, "wdt clear");
    // Wake with interrupts enabled goes to the vector
    run(OP_INTERRUPT_ENABLE_INSTR, 1'b0, 8'h00, 3'h0);
    chk(int_enable, 1'b1, "int on");
    run(OP_SLEEP, 1'b0, 8'h00, 3'h0);
    @(posedge ref_clk);
    wake_event <= 1'b1;
    s_pl = 1'b0;
    repeat (4) begin
      #1;
      if (pc_load === 1'b1 && !s_pl) begin
        s_pl = 1'b1;
        s_tg = pc_target;
      end
      @(posedge ref_clk);
      wake_event <= 1'b0;
    end
    chk({int_enable, s_pl, s_tg}, {2'b01, 11'h008}, "wake vector");
    $display("halt test done");
    // Second reset in mid-run
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk(status, 8'h18, "second reset");
    end_sim;
  end
endmodule // tb_mcu_instruction_execute_unit
